// [hw/zamc_top.sv]
/*
  Zone access and MAC verification command interpreter with a classic
  Wishbone register slave. Software loads a command and starts it; the block
  checks legality, issues a memory request or drives the digest engine, and
  reports status. Assumes the digest engine, memory and temporary key
  logic run on clk_i and answer with single-cycle pulses.
*/
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps

// Behaviour
// - Zone selector 0 config, 1 one-time, 2 data
// - One-time reads only after value lock, not legacy
// - No one-time or data writes before config lock, all before value
// - After value lock, one-time writes follow mode
// - After value lock, data writes follow slot permission
// - Word units; unused address bits must be zero
// - Offset bits 2..0, slot bits per zone
// - Data slots 0 to 15, all offsets
// - Secret slots allow full-block accesses only
// - Config blocks 0 to 2, no read above 16
// - Config words above 10 single-word only
// - Config words below 4, above 15 never written
// - Read-only one-time zone readable at all offsets
// - Consumption mode also allows one-time writes
// - MAC verify computes digest, returns pass or fail
// - Mode bit 2 selects required nonce kind
// - Copy target is slot plus one if even
// - Copy only for mode 1 or 5, checks pass
// - Mode bits 7-6, 4-3 zero; bit 5 message
// - Mode bit 2 must equal key source flag; the code checks it only when a message half comes from the temporary key
// - Mode bit 1 selects first message half
// - Mode bit 0 selects second message half
// - Result byte zero on match, one on mismatch
module zamc_top
  import zamc_pkg::*;
(
  input wire logic clk_i, // Block clock, 10 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic tkey_valid_i, // Temporary key holds a value
  input wire logic tkey_fixed_i, // Temporary key source flag, 1 fixed nonce
  input wire logic digest_done_i, // Digest engine finished, pulse
  input wire logic digest_match_i, // Digest equals client response
  output logic mem_req_o, // Legal memory access, pulse
  output logic mem_we_o, // Memory access is a write
  output logic mem_full_o, // Memory access is 32 bytes
  output logic [1:0] mem_zone_o, // Zone of the access
  output logic [3:0] mem_slot_o, // Slot of the access
  output logic [2:0] mem_offset_o, // Word offset of the access
  output logic hash_start_o, // Start digest engine, pulse
  output logic key_from_tkey_o, // First 32 bytes from temporary key
  output logic chal_from_tkey_o, // Second 32 bytes from temporary key
  output logic msg_from_otz_o, // 8-byte field from one-time zone
  output logic tkey_load_o, // Copy slot into temporary key, pulse
  output logic [3:0] tkey_slot_o, // Slot to copy
  output logic [7:0] result_o // Result byte of last MAC verify
);
  // Register file
  logic [31:0] cmd_r; // Opcode, first and second parameter
  logic full_r; // 32-byte access requested
  logic start_r; // Start pulse from a control write
  logic [3:0] lock_r; // Locks and one-time zone mode
  logic [15:0] secret_r; // Per-slot secret flags
  logic [15:0] wperm_r; // Per-slot write permission decision
  logic [15:0] rkzero_r; // Per-slot read-key field is zero
  logic [15:0] macsrc_r; // Per-slot MAC source bit
  // Status
  zamc_state_t st_r; // Sequencer state
  zamc_state_t st_nxt; // Next state
  logic done_r; // Last command finished
  logic err_r; // Last command aborted
  logic miss_r; // Last MAC verify mismatched
  logic copy_r; // Last command copied a key
  logic [31:0] rd_data; // Read multiplexer
  // Command decode
  logic [7:0] opcode; // Opcode byte
  logic [7:0] mode; // First parameter
  logic [3:0] slot_id; // Slot selector of MAC verify
  logic is_rw; // Read or write command
  logic is_mac; // MAC verify command
  logic acc_ok; // Access legality from checker
  logic [3:0] acc_slot; // Decoded slot
  logic [2:0] acc_ofs; // Decoded offset
  logic tkey_used; // Temporary key takes part in the digest
  logic mode_ok; // MAC verify fields legal
  logic go; // Start accepted
  logic [3:0] target; // Copy target slot
  logic copy_ok; // Copy conditions hold
  logic wr_stb; // Bus write taken

  assign opcode = cmd_r[7:0];
  assign mode = cmd_r[15:8];
  assign slot_id = cmd_r[19:16];
  assign is_rw = (opcode == ZAMC_OP_READ) || (opcode == ZAMC_OP_WRITE);
  assign is_mac = (opcode == ZAMC_OP_MACVFY);
  assign go = start_r && (st_r == ZAMC_IDLE);
  // Writes land at the edge where the master samples ack, while it still holds the request
  assign wr_stb = cyc_i && stb_i && we_i && ack_o;

  // Copy target: even selector uses its odd partner
  function automatic logic [3:0] copy_target(input logic [3:0] sid);
    copy_target = sid[0] ? sid : 4'(sid + 4'h1);
  endfunction

  assign target = copy_target(slot_id);

  // Temporary key is used when either message half comes from it
  assign tkey_used = mode[1] || mode[0];
  // Reserved mode bits, nonce kind and source flag checks
  assign mode_ok = (mode[7:6] == 2'b00) && (mode[4:3] == 2'b00)
    && (!tkey_used || (tkey_valid_i && mode[2] == tkey_fixed_i));
  // Copy needs the copy modes, zero read key and matching MAC source bit
  assign copy_ok = ((mode == ZAMC_MODE_COPY_A) || (mode == ZAMC_MODE_COPY_B))
    && rkzero_r[target] && (macsrc_r[target] == mode[2]);

  zamc_access_check u_check (
    .zone_i(cmd_r[15:8]),
    .addr_i(cmd_r[31:16]),
    .is_write_i(opcode == ZAMC_OP_WRITE),
    .full_i(full_r),
    .config_lock_i(lock_r[ZAMC_LOCK_CFG]),
    .value_lock_i(lock_r[ZAMC_LOCK_VAL]),
    .onetime_zone_mode_i(lock_r[ZAMC_LOCK_MODE_LO +: 2]),
    .secret_i(secret_r),
    .wperm_i(wperm_r),
    .ok_o(acc_ok),
    .slot_o(acc_slot),
    .offset_o(acc_ofs)
  );

  // Bus acknowledge: one wait state, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Software-written registers; byte selects honoured per lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r <= ZAMC_RST_CMD;
      full_r <= 1'b0;
      lock_r <= ZAMC_RST_LOCK;
      secret_r <= ZAMC_RST_SLOTS;
      wperm_r <= ZAMC_RST_SLOTS;
      rkzero_r <= ZAMC_RST_SLOTS;
      macsrc_r <= ZAMC_RST_SLOTS;
    end else if (wr_stb) begin
      unique case (adr_i)
        ZAMC_OFS_CMD: begin
          // Command is frozen while running so checks stay stable
          for (int i = 0; i < 4; i++) begin
            if (sel_i[i] && st_r == ZAMC_IDLE) begin
              cmd_r[i*8 +: 8] <= dat_i[i*8 +: 8];
            end
          end
        end
        ZAMC_OFS_CTRL: begin
          if (sel_i[0] && st_r == ZAMC_IDLE) begin
            full_r <= dat_i[ZAMC_CTRL_FULL];
          end
        end
        ZAMC_OFS_LOCK: begin
          if (sel_i[0]) begin
            lock_r <= dat_i[3:0];
          end
        end
        ZAMC_OFS_SECRET: begin
          if (sel_i[0]) secret_r[7:0] <= dat_i[7:0];
          if (sel_i[1]) secret_r[15:8] <= dat_i[15:8];
        end
        ZAMC_OFS_WPERM: begin
          if (sel_i[0]) wperm_r[7:0] <= dat_i[7:0];
          if (sel_i[1]) wperm_r[15:8] <= dat_i[15:8];
        end
        ZAMC_OFS_RKZERO: begin
          if (sel_i[0]) rkzero_r[7:0] <= dat_i[7:0];
          if (sel_i[1]) rkzero_r[15:8] <= dat_i[15:8];
        end
        ZAMC_OFS_MACSRC: begin
          if (sel_i[0]) macsrc_r[7:0] <= dat_i[7:0];
          if (sel_i[1]) macsrc_r[15:8] <= dat_i[15:8];
        end
        default: begin
          // Unmapped or read-only: write ignored, still acknowledged
        end
      endcase
    end
  end

  // Start pulse; a start while busy is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_stb && adr_i == ZAMC_OFS_CTRL && sel_i[0] && dat_i[ZAMC_CTRL_START]
        && st_r == ZAMC_IDLE;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    unique case (adr_i)
      ZAMC_OFS_CMD: rd_data = cmd_r;
      ZAMC_OFS_CTRL: rd_data = {30'h0000_0000, full_r, 1'b0};
      ZAMC_OFS_LOCK: rd_data = {28'h000_0000, lock_r};
      ZAMC_OFS_SECRET: rd_data = {16'h0000, secret_r};
      ZAMC_OFS_WPERM: rd_data = {16'h0000, wperm_r};
      ZAMC_OFS_RKZERO: rd_data = {16'h0000, rkzero_r};
      ZAMC_OFS_MACSRC: rd_data = {16'h0000, macsrc_r};
      ZAMC_OFS_STATUS: rd_data = {20'h0_0000, tkey_slot_o, 3'b000, copy_r, miss_r, err_r, done_r,
        (st_r != ZAMC_IDLE)};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data registered alongside the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      dat_o <= rd_data;
    end
  end

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ZAMC_IDLE: begin
        if (go) begin
          // Legal MAC verify waits on the digest; all else finishes now
          st_nxt = (is_mac && mode_ok) ? ZAMC_HASH : ZAMC_FIN;
        end
      end
      ZAMC_HASH: begin
        if (digest_done_i) begin
          st_nxt = ZAMC_FIN;
        end
      end
      ZAMC_FIN: begin
        st_nxt = ZAMC_IDLE;
      end
      default: begin
        st_nxt = ZAMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ZAMC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Memory request only for a legal read or write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_full_o <= 1'b0;
      mem_zone_o <= 2'b00;
      mem_slot_o <= 4'h0;
      mem_offset_o <= 3'b000;
    end else begin
      mem_req_o <= go && is_rw && acc_ok;
      if (go && is_rw && acc_ok) begin
        mem_we_o <= (opcode == ZAMC_OP_WRITE);
        mem_full_o <= full_r;
        mem_zone_o <= cmd_r[9:8];
        mem_slot_o <= acc_slot;
        mem_offset_o <= acc_ofs;
      end
    end
  end

  // Digest start and message source selects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hash_start_o <= 1'b0;
      key_from_tkey_o <= 1'b0;
      chal_from_tkey_o <= 1'b0;
      msg_from_otz_o <= 1'b0;
    end else begin
      hash_start_o <= go && is_mac && mode_ok;
      if (go && is_mac && mode_ok) begin
        key_from_tkey_o <= mode[1];
        chal_from_tkey_o <= mode[0];
        msg_from_otz_o <= mode[5];
      end
    end
  end

  // Result, copy and status flags; a new start clears done and copy, not miss or result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      miss_r <= 1'b0;
      copy_r <= 1'b0;
      tkey_load_o <= 1'b0;
      tkey_slot_o <= 4'h0;
      result_o <= 8'h00;
    end else begin
      tkey_load_o <= 1'b0;
      if (go) begin
        done_r <= 1'b0;
        copy_r <= 1'b0;
        // Illegal fields abort; nothing is requested or copied
        err_r <= is_mac ? !mode_ok : !(is_rw && acc_ok);
      end
      if (st_r == ZAMC_HASH && digest_done_i) begin
        miss_r <= !digest_match_i;
        result_o <= digest_match_i ? 8'h00 : 8'h01;
        if (digest_match_i && copy_ok) begin
          tkey_load_o <= 1'b1;
          tkey_slot_o <= target;
          copy_r <= 1'b1;
        end
      end
      if (st_r == ZAMC_FIN) begin
        done_r <= 1'b1;
      end
    end
  end

  // Checks on the design's own behaviour
  a_access_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    go && is_rw && !acc_ok |=> st_r == ZAMC_FIN && err_r && !mem_req_o ##1 done_r)
    else $error("illegal access not aborted");
  a_legal_request: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o |-> $past(go) && $past(acc_ok) && mem_zone_o == $past(cmd_r[9:8]))
    else $error("memory request without legal access");
  a_secret_block: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o && mem_zone_o == 2'b10 && !mem_full_o |-> !secret_r[mem_slot_o])
    else $error("single word on secret slot");
  a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o && mem_we_o && mem_zone_o == 2'b00 |-> !lock_r[ZAMC_LOCK_CFG]
      && {mem_slot_o[1:0], mem_offset_o} >= ZAMC_CFG_MIN_WRITE
      && {mem_slot_o[1:0], mem_offset_o} <= ZAMC_CFG_MAX_WRITE)
    else $error("protected config word written");
  a_early_write: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o && mem_we_o && mem_zone_o != 2'b00 |-> lock_r[ZAMC_LOCK_CFG])
    else $error("write before config lock");
  a_otz_read: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o && !mem_we_o && mem_zone_o == 2'b01 |-> lock_r[ZAMC_LOCK_VAL])
    else $error("one-time read before value lock");
  a_mode_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    go && is_mac && (mode[7:6] != 2'b00 || mode[4:3] != 2'b00) |=> !hash_start_o && err_r)
    else $error("reserved mode bits accepted");
  a_source_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    hash_start_o && (key_from_tkey_o || chal_from_tkey_o) |-> $past(mode[2]) == $past(tkey_fixed_i))
    else $error("nonce source flag mismatch");
  a_copy_target: assert property (@(posedge clk_i) disable iff (rst_i)
    tkey_load_o |-> tkey_slot_o == (slot_id[0] ? slot_id : slot_id + 4'h1) && result_o == 8'h00
      && (mode == ZAMC_MODE_COPY_A || mode == ZAMC_MODE_COPY_B))
    else $error("bad key copy");
  a_result_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == ZAMC_HASH && digest_done_i |=> result_o == {7'h00, !$past(digest_match_i)}
      ##1 done_r)
    else $error("result byte wrong");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
  c_mac_copy: cover property (@(posedge clk_i) disable iff (rst_i) tkey_load_o);
  c_mac_miss: cover property (@(posedge clk_i) disable iff (rst_i) st_r == ZAMC_HASH && digest_done_i
    && !digest_match_i);
  c_data_write: cover property (@(posedge clk_i) disable iff (rst_i) mem_req_o && mem_we_o
    && mem_zone_o == 2'b10);
  c_abort: cover property (@(posedge clk_i) disable iff (rst_i) go && is_rw && !acc_ok);
endmodule

// [inc/zamc_pkg.sv]
/*
  Shared constants and types of the zone access and MAC check block:
  register offsets, field positions, reset values, opcodes, zone and mode codes.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package zamc_pkg;
  // Register byte offsets
  localparam logic [7:0] ZAMC_OFS_CMD = 8'h00;
  localparam logic [7:0] ZAMC_OFS_CTRL = 8'h04;
  localparam logic [7:0] ZAMC_OFS_LOCK = 8'h08;
  localparam logic [7:0] ZAMC_OFS_SECRET = 8'h0C;
  localparam logic [7:0] ZAMC_OFS_WPERM = 8'h10;
  localparam logic [7:0] ZAMC_OFS_RKZERO = 8'h14;
  localparam logic [7:0] ZAMC_OFS_MACSRC = 8'h18;
  localparam logic [7:0] ZAMC_OFS_STATUS = 8'h1C;
  // Control register bits
  localparam int ZAMC_CTRL_START = 0;
  localparam int ZAMC_CTRL_FULL = 1;
  // Lock register bits
  localparam int ZAMC_LOCK_CFG = 0;
  localparam int ZAMC_LOCK_VAL = 1;
  localparam int ZAMC_LOCK_MODE_LO = 2;
  // Status register bits
  localparam int ZAMC_ST_BUSY = 0;
  localparam int ZAMC_ST_DONE = 1;
  localparam int ZAMC_ST_ERR = 2;
  localparam int ZAMC_ST_MISS = 3;
  localparam int ZAMC_ST_COPY = 4;
  localparam int ZAMC_ST_CSLOT_LO = 8;
  // Reset values
  localparam logic [31:0] ZAMC_RST_CMD = 32'h0000_0000;
  localparam logic [3:0] ZAMC_RST_LOCK = 4'h0;
  localparam logic [15:0] ZAMC_RST_SLOTS = 16'h0000;
  // Opcodes
  localparam logic [7:0] ZAMC_OP_READ = 8'h02;
  localparam logic [7:0] ZAMC_OP_WRITE = 8'h12;
  localparam logic [7:0] ZAMC_OP_MACVFY = 8'h28;
  // Zone selector codes
  localparam logic [7:0] ZAMC_ZONE_CFG = 8'h00;
  localparam logic [7:0] ZAMC_ZONE_OTZ = 8'h01;
  localparam logic [7:0] ZAMC_ZONE_DATA = 8'h02;
  // One-time zone operating modes
  localparam logic [1:0] ZAMC_OTZ_READONLY = 2'h0;
  localparam logic [1:0] ZAMC_OTZ_CONSUME = 2'h1;
  localparam logic [1:0] ZAMC_OTZ_LEGACY = 2'h2;
  // Configuration word limits
  localparam logic [4:0] ZAMC_CFG_MAX_READ = 5'h10;
  localparam logic [4:0] ZAMC_CFG_MAX_BLOCK = 5'h0A;
  localparam logic [4:0] ZAMC_CFG_MIN_WRITE = 5'h04;
  localparam logic [4:0] ZAMC_CFG_MAX_WRITE = 5'h0F;
  localparam logic [1:0] ZAMC_CFG_LAST_BLK = 2'h2;
  // Mode values that allow a key copy
  localparam logic [7:0] ZAMC_MODE_COPY_A = 8'h01;
  localparam logic [7:0] ZAMC_MODE_COPY_B = 8'h05;
  // Sequencer states, Gray along idle, hash, finish
  typedef enum logic [1:0] {
    ZAMC_IDLE = 2'b00,
    ZAMC_HASH = 2'b01,
    ZAMC_FIN = 2'b11
  } zamc_state_t;

  // Configuration word number from block and offset
  function automatic logic [4:0] zamc_cfg_word(input logic [1:0] blk, input logic [2:0] ofs);
    zamc_cfg_word = {blk, ofs};
  endfunction
endpackage

// [hw/zamc_access_check.sv]
/*
  Combinational legality check for read and write commands: zone selector,
  address layout, lock state, slot flags and access size.
  Assumes all inputs are stable on the block clock; no state is held here.
*/
`timescale 1ns/1ps
module zamc_access_check
  import zamc_pkg::*;
(
  input wire logic [7:0] zone_i, // First parameter byte
  input wire logic [15:0] addr_i, // Second parameter
  input wire logic is_write_i, // High for a write
  input wire logic full_i, // High for a 32-byte access
  input wire logic config_lock_i, // Configuration locked
  input wire logic value_lock_i, // Value and one-time zone locked
  input wire logic [1:0] onetime_zone_mode_i, // One-time zone mode
  input wire logic [15:0] secret_i, // Per-slot secret flags
  input wire logic [15:0] wperm_i, // Per-slot write allowed after value lock
  output logic ok_o, // Access legal
  output logic [3:0] slot_o, // Decoded slot or block
  output logic [2:0] offset_o // Word offset within the slot
);
  logic [4:0] cword; // Configuration word number

  // Decode address and apply zone rules
  always_comb begin
    cword = zamc_cfg_word(addr_i[4:3], addr_i[2:0]);
    offset_o = addr_i[2:0];
    slot_o = 4'h0;
    ok_o = 1'b0;
    // Upper byte and bit 7 must be zero in every zone
    if (addr_i[15:7] == 9'h000) begin
      unique case (zone_i)
        ZAMC_ZONE_CFG: begin
          slot_o = {2'b00, addr_i[4:3]};
          ok_o = (addr_i[6:5] == 2'b00) && (addr_i[4:3] <= ZAMC_CFG_LAST_BLK);
          if (full_i && cword > ZAMC_CFG_MAX_BLOCK) begin
            ok_o = 1'b0;
          end
          if (is_write_i) begin
            // Locked configuration and protected words never written
            if (config_lock_i || cword < ZAMC_CFG_MIN_WRITE || cword > ZAMC_CFG_MAX_WRITE) begin
              ok_o = 1'b0;
            end
          end else if (cword > ZAMC_CFG_MAX_READ) begin
            ok_o = 1'b0;
          end
        end
        ZAMC_ZONE_OTZ: begin
          slot_o = {3'b000, addr_i[3]};
          ok_o = (addr_i[6:4] == 3'b000);
          if (is_write_i) begin
            if (!config_lock_i) begin
              ok_o = 1'b0;
            end else if (value_lock_i && onetime_zone_mode_i != ZAMC_OTZ_CONSUME) begin
              ok_o = 1'b0;
            end
          end else if (!value_lock_i || onetime_zone_mode_i == ZAMC_OTZ_LEGACY) begin
            // Legacy rules are not modelled, so legacy reads are refused
            ok_o = 1'b0;
          end
        end
        ZAMC_ZONE_DATA: begin
          slot_o = addr_i[6:3];
          ok_o = 1'b1;
          if (!full_i && secret_i[addr_i[6:3]]) begin
            ok_o = 1'b0;
          end
          if (is_write_i) begin
            if (!config_lock_i) begin
              ok_o = 1'b0;
            end else if (value_lock_i && !wperm_i[addr_i[6:3]]) begin
              ok_o = 1'b0;
            end
          end
        end
        default: begin
          ok_o = 1'b0;
        end
      endcase
    end
  end
endmodule

// [tb/zamc_digest_model.sv]
/*
  Digest engine stand-in: a done pulse follows each hash start after a delay.
  Assumes one hash at a time, start a one-cycle pulse on clk_i.
*/
`timescale 1ns/1ps
module zamc_digest_model (
  input wire logic clk_i, // Block clock
  input wire logic rst_i, // Synchronous reset
  input wire logic start_i, // Hash start pulse
  input wire logic [3:0] delay_i, // Extra wait cycles
  input wire logic match_i, // Outcome to report
  output logic done_o, // Done pulse
  output logic match_o // Match, valid with done only
);
  logic [4:0] cnt_r; // Cycles left, zero when idle
  // Count down from the start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
    end else if (start_i) begin
      cnt_r <= {1'b0, delay_i} + 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
  // Match toggles outside done, so a sample taken without done can read the wrong answer
  always_ff @(posedge clk_i) begin
    done_o <= (cnt_r == 5'h01) && !rst_i;
    match_o <= rst_i ? 1'b0 : (cnt_r == 5'h01) ? match_i : ~match_o;
  end
endmodule

// [tb/tb_top.sv]
/*
  Bench: runs read, write and MAC verify commands over the register bus.
  Assumes the digest model answers every hash start.
*/
`timescale 1ns/1ps
module tb_top
  import zamc_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0; // Clock, reset, bus
  logic [7:0] adr_i = 8'h00; // Bus address
  logic [3:0] sel_i = 4'h0; // Byte selects
  logic [31:0] dat_i = 32'h0000_0000; // Write data
  logic tkey_valid_i = 1'b0, tkey_fixed_i = 1'b0, eng_match = 1'b1; // Key state, engine outcome
  logic [3:0] eng_delay = 4'h2; // Engine latency
  logic [31:0] dat_o, rd_q; // Read data, last taken
  logic ack_o, mem_req_o, mem_we_o, mem_full_o, hash_start_o, key_from_tkey_o, chal_from_tkey_o;
  logic msg_from_otz_o, tkey_load_o, digest_done_i, digest_match_i;
  logic [1:0] mem_zone_o;
  logic [3:0] mem_slot_o, tkey_slot_o;
  logic [2:0] mem_offset_o;
  logic [7:0] result_o;
  int err_count = 0, num_checks = 0, req_cnt = 0, hash_cnt = 0, load_cnt = 0;
  always #50 clk_i = ~clk_i;
  // Tally strobes at the edge that samples them
  always @(posedge clk_i) begin
    if (mem_req_o === 1'b1) req_cnt++;
    if (hash_start_o === 1'b1) hash_cnt++;
    if (tkey_load_o === 1'b1) load_cnt++;
  end
  zamc_top zamc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tkey_valid_i(tkey_valid_i),
    .tkey_fixed_i(tkey_fixed_i), .digest_done_i(digest_done_i), .digest_match_i(digest_match_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_full_o(mem_full_o), .mem_zone_o(mem_zone_o),
    .mem_slot_o(mem_slot_o), .mem_offset_o(mem_offset_o), .hash_start_o(hash_start_o),
    .key_from_tkey_o(key_from_tkey_o), .chal_from_tkey_o(chal_from_tkey_o), .msg_from_otz_o(msg_from_otz_o),
    .tkey_load_o(tkey_load_o), .tkey_slot_o(tkey_slot_o), .result_o(result_o));
  zamc_digest_model zamc_digest_model_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(hash_start_o),
    .delay_i(eng_delay), .match_i(eng_match), .done_o(digest_done_i), .match_o(digest_match_i));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd_q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack", 32'h1, {31'h0, ack_o});
    if (ack_o !== 1'b1) finish_test();
    @(posedge clk_i);
  endtask
  // Load, start, poll until done, compare status and strobes
  task automatic run(input logic [31:0] c, input logic f, input logic [4:0] e);
    int r, h, l, n;
    logic mac;
    logic [3:0] s;
    r = req_cnt;
    h = hash_cnt;
    l = load_cnt;
    n = 0;
    mac = (c[7:0] == ZAMC_OP_MACVFY);
    s = (c[9:8] == 2'h2) ? c[22:19] : (c[9:8] == 2'h0) ? {2'h0, c[20:19]} : {3'h0, c[19]};
    bus(1'b1, ZAMC_OFS_CMD, c);
    bus(1'b1, ZAMC_OFS_CTRL, {30'h0, f, 1'b1});
    do begin
      bus(1'b0, ZAMC_OFS_STATUS, 32'h0);
      n++;
    end while (rd_q[ZAMC_ST_DONE] !== 1'b1 && n < 40);
    chk("status", {27'h0, e}, {27'h0, rd_q[4:0]});
    if (rd_q[ZAMC_ST_DONE] !== 1'b1) finish_test();
    chk("mem_req", {31'h0, !mac && !e[2]}, 32'(req_cnt - r));
    chk("hash", {31'h0, mac && !e[2]}, 32'(hash_cnt - h));
    chk("load", {31'h0, e[4]}, 32'(load_cnt - l));
    if (!mac && !e[2]) chk("mem", {c[7:0] == ZAMC_OP_WRITE, f, c[9:8], s, c[18:16]},
      {mem_we_o, mem_full_o, mem_zone_o, mem_slot_o, mem_offset_o});
    if (mac && !e[2]) chk("result", {31'h0, e[3]}, {24'h0, result_o});
    if (mac && !e[2]) chk("route", {29'h0, c[9], c[8], c[13]},
      {29'h0, key_from_tkey_o, chal_from_tkey_o, msg_from_otz_o});
    if (e[4]) chk("copy", {28'h0, c[16] ? c[19:16] : c[19:16] + 4'h1}, {28'h0, tkey_slot_o});
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    run(32'h0015_0202, 1'b0, 5'h02);
    run(32'h007F_0202, 1'b0, 5'h02);
    run(32'h0000_0212, 1'b0, 5'h06);
    run(32'h0000_0302, 1'b0, 5'h06);
    run(32'h0100_0002, 1'b0, 5'h06);
    run(32'h0018_0002, 1'b0, 5'h06);
    run(32'h0011_0002, 1'b0, 5'h06);
    run(32'h0010_0002, 1'b0, 5'h02);
    run(32'h0010_0002, 1'b1, 5'h06);
    run(32'h0008_0002, 1'b1, 5'h02);
    run(32'h0000_0102, 1'b0, 5'h06);
    // Configuration words 4 to 15 only are writable while configuration is still open
    run(32'h0003_0012, 1'b0, 5'h06);
    run(32'h0004_0012, 1'b0, 5'h02);
    run(32'h000F_0012, 1'b0, 5'h02);
    run(32'h0010_0012, 1'b0, 5'h06);
    bus(1'b1, ZAMC_OFS_LOCK, 32'h1);
    bus(1'b0, ZAMC_OFS_LOCK, 32'h0);
    chk("lock", 32'h1, rd_q);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    bus(1'b1, ZAMC_OFS_SECRET, 32'h20);
    bus(1'b1, ZAMC_OFS_WPERM, 32'h4);
    bus(1'b1, ZAMC_OFS_RKZERO, 32'h8);
    bus(1'b1, ZAMC_OFS_MACSRC, 32'h0);
    run(32'h0004_0012, 1'b0, 5'h06);
    run(32'h000F_0112, 1'b0, 5'h02);
    run(32'h0028_0202, 1'b0, 5'h06);
    run(32'h0028_0202, 1'b1, 5'h02);
    run(32'h0030_0212, 1'b0, 5'h02);
    bus(1'b1, ZAMC_OFS_LOCK, 32'h3);
    run(32'h000F_0102, 1'b0, 5'h02);
    run(32'h0008_0112, 1'b0, 5'h06);
    run(32'h0010_0212, 1'b0, 5'h02);
    run(32'h0030_0212, 1'b0, 5'h06);
    bus(1'b1, ZAMC_OFS_LOCK, 32'h7);
    run(32'h0008_0112, 1'b1, 5'h02);
    bus(1'b1, ZAMC_OFS_LOCK, 32'hB);
    run(32'h0000_0102, 1'b0, 5'h06);
    run(32'h0004_0028, 1'b0, 5'h02);
    tkey_valid_i <= 1'b1;
    run(32'h0002_0128, 1'b0, 5'h12);
    eng_match <= 1'b0;
    eng_delay <= 4'hC;
    run(32'h0003_0128, 1'b0, 5'h0A);
    eng_match <= 1'b1;
    eng_delay <= 4'h0;
    // Mismatch flag of the previous verify stays until the next digest result
    run(32'h0003_0528, 1'b0, 5'h0E);
    tkey_fixed_i <= 1'b1;
    run(32'h0003_0528, 1'b0, 5'h02);
    run(32'h0002_0128, 1'b0, 5'h06);
    tkey_fixed_i <= 1'b0;
    run(32'h0000_2328, 1'b0, 5'h02);
    run(32'h0000_4028, 1'b0, 5'h06);
    run(32'h0000_0828, 1'b0, 5'h06);
    tkey_valid_i <= 1'b0;
    run(32'h0000_0128, 1'b0, 5'h06);
    finish_test();
  end
endmodule
